/* File: hdl/cad_datapath.sv */
// Central ALU, accumulator, shifters and auxiliary registers
`timescale 1ns/1ps
module cad_datapath (
  input  wire logic             core_clk_in,
  input  wire logic             sys_rst_in,
  input  wire logic             psel_in,
  input  wire logic             penable_in,
  input  wire logic             pwrite_in,
  input  wire logic [7:0]       paddr_in,
  input  wire logic [31:0]      pwdata_in,
  output logic      [31:0]      prdata_out,
  output logic                  pready_out,
  output logic                  pslverr_out,
  input  wire logic             op_valid_in,
  input  cad_pkg::cad_op_t      op_code_in,
  input  wire logic [15:0]      op_data_in,
  input  wire logic [4:0]       op_shift_in,
  input  wire logic [3:0]       op_arg_in,
  input  wire logic [1:0]       aux_mod_in,
  input  wire logic [31:0]      product_in,
  input  wire logic [15:0]      mul_opnd_in,
  input  wire logic             ovf_test_in,
  output logic      [31:0]      accum_out,
  output logic      [15:0]      store_data_out,
  output logic                  store_valid_out,
  output logic                  carry_out,
  output logic                  overflow_out,
  output logic                  accum_zero_out,
  output logic      [15:0]      branch_addr_out,
  output logic                  branch_valid_out,
  output logic                  bit_test_out,
  output logic      [15:0]      aux_addr_out
);
  localparam int AW = cad_pkg::ACCUM_W;
  localparam int DW = cad_pkg::DATA_W;

  logic [AW-1:0] accum_q, accum_d;
  logic          carry_q, carry_d, ovf_flag_q, ovf_flag_d;
  logic          sat_en_q, sat_en_d, sext_q, sext_d, zero_q, zero_d;
  logic [1:0]    psm_q, psm_d;
  logic [2:0]    ptr_q, ptr_d;
  logic [DW-1:0] aux_q [8];
  logic [DW-1:0] aux_d [8];
  logic [DW-1:0] store_q, store_d, branch_q, branch_d, addr_q, addr_d;
  logic          store_v_q, store_v_d, branch_v_q, branch_v_d;
  logic          bit_q, bit_d;
  logic [31:0]   prdata_q, prdata_d, stat_w;
  logic          pready_q, pready_d, perr_q, perr_d;
  logic [AW-1:0] product_shifter_v, opnd_b, b_eff, raw_res, arith_res, store_sh;
  logic [AW:0]   sum;
  logic [4:0]    var_sh;
  logic [2:0]    st_sh;
  logic          arith, subtr, cin, ovf, hi16, setup, apb_wr, ovf_clr;
  logic          set_v;

  function automatic logic [AW-1:0] input_scaling_shifter(input logic [DW-1:0] d,
                                           input logic [4:0]    sh,
                                           input logic          sx);
    logic [AW-1:0] e;
    e = {{DW{sx & d[DW-1]}}, d};
    if (sh > cad_pkg::INPUT_SCALING_SHIFTER_MAX) begin
      input_scaling_shifter = e << cad_pkg::INPUT_SCALING_SHIFTER_MAX;
    end else begin
      input_scaling_shifter = e << sh;
    end
  endfunction : input_scaling_shifter

  // Operand path and adder
  always_comb begin
    unique case (psm_q)
      cad_pkg::PSM_NONE:   product_shifter_v = product_in;
      cad_pkg::PSM_LEFT1:  product_shifter_v = product_in << cad_pkg::PRODUCT_SHIFTER_L1;
      cad_pkg::PSM_LEFT4:  product_shifter_v = product_in << cad_pkg::PRODUCT_SHIFTER_L4;
      cad_pkg::PSM_RIGHT6: begin
        product_shifter_v = AW'($signed(product_in) >>> cad_pkg::PRODUCT_SHIFTER_R6);
      end
    endcase
    var_sh = {1'b0, mul_opnd_in[3:0]};
    case (op_code_in)
      cad_pkg::OP_LOAD_VAR, cad_pkg::OP_ADD_VAR, cad_pkg::OP_SUB_VAR: begin
        opnd_b = input_scaling_shifter(op_data_in, var_sh, sext_q);
      end
      cad_pkg::OP_LOAD_PROD, cad_pkg::OP_ADD_PROD, cad_pkg::OP_SUB_PROD: begin
        opnd_b = product_shifter_v;
      end
      cad_pkg::OP_ADD_AUX: opnd_b = {{(AW-DW){1'b0}}, aux_q[ptr_q]};
      default: opnd_b = input_scaling_shifter(op_data_in, op_shift_in, sext_q);
    endcase
    subtr = op_code_in inside {cad_pkg::OP_SUB, cad_pkg::OP_SUB_BORROW,
                               cad_pkg::OP_SUB_VAR, cad_pkg::OP_SUB_PROD};
    arith = op_valid_in & (subtr | op_code_in inside {cad_pkg::OP_ADD,
            cad_pkg::OP_ADD_CARRY, cad_pkg::OP_ADD_VAR,
            cad_pkg::OP_ADD_PROD, cad_pkg::OP_ADD_AUX});
    if (op_code_in inside {cad_pkg::OP_ADD_CARRY, cad_pkg::OP_SUB_BORROW}) begin
      cin = carry_q;
    end else begin
      cin = subtr;
    end
    b_eff = subtr ? ~opnd_b : opnd_b;
    sum = {1'b0, accum_q} + {1'b0, b_eff} + {{AW{1'b0}}, cin};
    raw_res = sum[AW-1:0];
    ovf = arith & (accum_q[AW-1] == b_eff[AW-1]) &
          (raw_res[AW-1] != accum_q[AW-1]);
    if (ovf && sat_en_q) begin
      arith_res = accum_q[AW-1] ? cad_pkg::SAT_NEG : cad_pkg::SAT_POS;
    end else begin
      arith_res = raw_res;
    end
    hi16 = arith & (op_shift_in == cad_pkg::INPUT_SCALING_SHIFTER_MAX) &
           (op_code_in inside {cad_pkg::OP_ADD, cad_pkg::OP_SUB});
    st_sh = op_shift_in[2:0];
    store_sh = accum_q << st_sh;
  end

  // Accumulator and flags
  always_comb begin
    accum_d = accum_q;
    carry_d = carry_q;
    sat_en_d = sat_en_q;
    sext_d = sext_q;
    psm_d = psm_q;
    ovf_flag_d = ovf_flag_q & ~ovf_clr;
    set_v = op_code_in == cad_pkg::OP_SET_FLAG;
    if (apb_wr && paddr_in == cad_pkg::REG_STATUS) begin
      sat_en_d = pwdata_in[cad_pkg::ST_SATEN];
      sext_d = pwdata_in[cad_pkg::ST_SEXT];
      psm_d = pwdata_in[cad_pkg::ST_PSM +: 2];
    end
    if (op_valid_in) begin
      case (op_code_in)
        cad_pkg::OP_LOAD, cad_pkg::OP_LOAD_VAR, cad_pkg::OP_LOAD_PROD: begin
          accum_d = opnd_b;
        end
        cad_pkg::OP_AND: accum_d = accum_q & opnd_b;
        cad_pkg::OP_OR:  accum_d = accum_q | opnd_b;
        cad_pkg::OP_XOR: accum_d = accum_q ^ opnd_b;
        cad_pkg::OP_SHL1: {carry_d, accum_d} = {accum_q, 1'b0};
        cad_pkg::OP_SHR1: begin
          {accum_d, carry_d} = {sext_q & accum_q[AW-1], accum_q};
        end
        cad_pkg::OP_ROT_L: {carry_d, accum_d} = {accum_q, carry_q};
        cad_pkg::OP_ROT_R: {accum_d, carry_d} = {carry_q, accum_q};
        cad_pkg::OP_NORMALIZE: begin
          if (accum_q != '0 && accum_q[AW-1] == accum_q[AW-2]) begin
            accum_d = accum_q << 1;
          end
        end
        cad_pkg::OP_SET_FLAG, cad_pkg::OP_CLR_FLAG: begin
          case (op_arg_in[1:0])
            cad_pkg::FLAG_CARRY: carry_d = set_v;
            cad_pkg::FLAG_SEXT:  sext_d = set_v;
            cad_pkg::FLAG_SATEN: sat_en_d = set_v;
            default: ;
          endcase
        end
        cad_pkg::OP_LOAD_STAT: begin
          carry_d = op_data_in[cad_pkg::ST_C];
          sext_d = op_data_in[cad_pkg::ST_SEXT];
          psm_d = op_data_in[cad_pkg::ST_PSM +: 2];
        end
        default: begin
          if (arith) begin
            accum_d = arith_res;
            if (hi16 && subtr) begin
              carry_d = carry_q & sum[AW];
            end else if (hi16) begin
              carry_d = carry_q | sum[AW];
            end else begin
              carry_d = sum[AW];
            end
          end
        end
      endcase
    end
    ovf_flag_d = ovf_flag_d | ovf;
    zero_d = accum_d == '0;
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      accum_q <= '0;
      carry_q <= cad_pkg::CARRY_RST;
      ovf_flag_q <= 1'b0;
      sat_en_q <= 1'b0;
      sext_q <= cad_pkg::SEXT_RST;
      psm_q <= cad_pkg::PSM_NONE;
      zero_q <= 1'b1;
    end else begin
      accum_q <= accum_d;
      carry_q <= carry_d;
      ovf_flag_q <= ovf_flag_d;
      sat_en_q <= sat_en_d;
      sext_q <= sext_d;
      psm_q <= psm_d;
      zero_q <= zero_d;
    end
  end

  // Auxiliary registers and pointer
  always_comb begin
    aux_d = aux_q;
    ptr_d = ptr_q;
    if (op_valid_in) begin
      unique case (aux_mod_in)
        cad_pkg::MOD_NONE: ;
        cad_pkg::MOD_INC:  aux_d[ptr_q] = aux_q[ptr_q] + cad_pkg::AUX_STEP;
        cad_pkg::MOD_DEC:  aux_d[ptr_q] = aux_q[ptr_q] - cad_pkg::AUX_STEP;
        cad_pkg::MOD_IDX0: aux_d[ptr_q] = aux_q[ptr_q] + aux_q[0];
      endcase
      case (op_code_in)
        cad_pkg::OP_AUX_LD:       aux_d[ptr_q] = op_data_in;
        cad_pkg::OP_AUX_LD_ACCUM: aux_d[ptr_q] = accum_q[DW-1:0];
        cad_pkg::OP_AUX_LD_PROD:  aux_d[ptr_q] = product_in[DW-1:0];
        cad_pkg::OP_PTR_LD:       ptr_d = op_data_in[2:0];
        cad_pkg::OP_LOAD_STAT:    ptr_d = op_data_in[cad_pkg::ST_PTR +: 3];
        default: ;
      endcase
    end
    addr_d = aux_d[ptr_d];
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      aux_q <= '{default: '0};
      ptr_q <= '0;
      addr_q <= '0;
    end else begin
      aux_q <= aux_d;
      ptr_q <= ptr_d;
      addr_q <= addr_d;
    end
  end

  // Store, branch, bit test and register bus
  always_comb begin
    store_d = store_q;
    store_v_d = 1'b0;
    branch_d = branch_q;
    branch_v_d = 1'b0;
    bit_d = bit_q;
    if (op_valid_in) begin
      case (op_code_in)
        cad_pkg::OP_STORE_HI: begin
          store_d = store_sh[AW-1:DW];
          store_v_d = 1'b1;
        end
        cad_pkg::OP_STORE_LO: begin
          store_d = store_sh[DW-1:0];
          store_v_d = 1'b1;
        end
        cad_pkg::OP_STORE_AUX: begin
          store_d = aux_q[ptr_q];
          store_v_d = 1'b1;
        end
        cad_pkg::OP_BRANCH_COMP: begin
          branch_d = accum_q[DW-1:0];
          branch_v_d = 1'b1;
        end
        cad_pkg::OP_BIT_TEST: bit_d = op_data_in[op_arg_in];
        cad_pkg::OP_BIT_VAR:  bit_d = op_data_in[mul_opnd_in[3:0]];
        default: ;
      endcase
    end
    setup = psel_in & ~penable_in;
    apb_wr = psel_in & penable_in & pready_q & pwrite_in;
    ovf_clr = ovf_test_in | (apb_wr & (paddr_in == cad_pkg::REG_STATUS) &
              pwdata_in[cad_pkg::ST_OVF]);
    stat_w = '0;
    stat_w[cad_pkg::ST_C] = carry_q;
    stat_w[cad_pkg::ST_OVF] = ovf_flag_q;
    stat_w[cad_pkg::ST_ZERO] = zero_q;
    stat_w[cad_pkg::ST_SEXT] = sext_q;
    stat_w[cad_pkg::ST_SATEN] = sat_en_q;
    stat_w[cad_pkg::ST_PSM +: 2] = psm_q;
    stat_w[cad_pkg::ST_PTR +: 3] = ptr_q;
    pready_d = setup;
    perr_d = 1'b0;
    prdata_d = prdata_q;
    if (setup) begin
      case (paddr_in)
        cad_pkg::REG_STATUS: prdata_d = stat_w;
        cad_pkg::REG_ACCUM:  prdata_d = accum_q;
        cad_pkg::REG_AUX:    prdata_d = {{(AW-DW){1'b0}}, aux_q[ptr_q]};
        default: begin
          prdata_d = '0;
          perr_d = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      store_q <= '0;
      store_v_q <= 1'b0;
      branch_q <= '0;
      branch_v_q <= 1'b0;
      bit_q <= 1'b0;
      prdata_q <= '0;
      pready_q <= 1'b0;
      perr_q <= 1'b0;
    end else begin
      store_q <= store_d;
      store_v_q <= store_v_d;
      branch_q <= branch_d;
      branch_v_q <= branch_v_d;
      bit_q <= bit_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      perr_q <= perr_d;
    end
  end

  assign prdata_out = prdata_q;
  assign pready_out = pready_q;
  assign pslverr_out = perr_q;
  assign accum_out = accum_q;
  assign store_data_out = store_q;
  assign store_valid_out = store_v_q;
  assign carry_out = carry_q;
  assign overflow_out = ovf_flag_q;
  assign accum_zero_out = zero_q;
  assign branch_addr_out = branch_q;
  assign branch_valid_out = branch_v_q;
  assign bit_test_out = bit_q;
  assign aux_addr_out = addr_q;

  // Checks
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  sequence sat_ovf_s;
    arith && ovf && sat_en_q;
  endsequence
  sequence rot_l_s;
    op_valid_in && op_code_in == cad_pkg::OP_ROT_L;
  endsequence
  sequence rot_r_s;
    op_valid_in && op_code_in == cad_pkg::OP_ROT_R;
  endsequence

  sat_clamp_a: assert property (
    sat_ovf_s |=> overflow_out && (accum_out == ($past(accum_q[AW-1]) ?
      cad_pkg::SAT_NEG : cad_pkg::SAT_POS)))
    else $error("saturated overflow not clamped");
  wrap_keep_a: assert property (
    arith && ovf && !sat_en_q |=> accum_out == $past(raw_res))
    else $error("unsaturated overflow lost sum");
  logic_no_ovf_a: assert property (
    op_valid_in && op_code_in inside {cad_pkg::OP_AND, cad_pkg::OP_OR,
      cad_pkg::OP_XOR} && !overflow_out |=> !overflow_out)
    else $error("boolean op raised overflow");
  carry_hold_a: assert property (
    op_valid_in && op_code_in inside {cad_pkg::OP_LOAD, cad_pkg::OP_AND,
      cad_pkg::OP_LOAD_PROD, cad_pkg::OP_XOR} |=> $stable(carry_out))
    else $error("carry moved on load or logic");
  high_carry_a: assert property (
    hi16 |=> ($past(subtr) ? (carry_out <= $past(carry_q))
                           : (carry_out >= $past(carry_q))))
    else $error("high-half op moved carry wrong way");
  shr_one_a: assert property (
    op_valid_in && op_code_in == cad_pkg::OP_SHR1 |=>
      accum_out[AW-2:0] == $past(accum_q[AW-1:1]) &&
      accum_out[AW-1] == ($past(sext_q) & $past(accum_q[AW-1])) &&
      carry_out == $past(accum_q[0]))
    else $error("right shift through carry wrong");
  rot_pair_a: assert property (
    rot_l_s ##1 rot_r_s |=> accum_out == $past(accum_q, 2) &&
      carry_out == $past(carry_q, 2))
    else $error("rotate pair did not restore");
  store_lo_a: assert property (
    op_valid_in && op_code_in == cad_pkg::OP_STORE_LO |=> store_valid_out &&
      store_data_out == DW'($past(accum_q) << $past(st_sh)) &&
      $stable(accum_out))
    else $error("low store shift wrong");
  ovf_sticky_a: assert property (
    overflow_out && !ovf_clr |=> overflow_out)
    else $error("overflow flag dropped");
  zero_cond_a: assert property (
    accum_zero_out == (accum_out == '0))
    else $error("zero condition disagrees");
  aux_step_a: assert property (
    op_valid_in && aux_mod_in == cad_pkg::MOD_INC && !(op_code_in inside
      {cad_pkg::OP_AUX_LD, cad_pkg::OP_AUX_LD_ACCUM, cad_pkg::OP_AUX_LD_PROD})
      |=> aux_q[$past(ptr_q)] == $past(addr_q) + cad_pkg::AUX_STEP)
    else $error("auxiliary increment wrong");
endmodule : cad_datapath

/* File: shared/cad_pkg.sv */
// Shared constants and types for the central ALU datapath
// What this block does
// - First ALU input is the accumulator; second is product, scaler or auxiliary register
// - ALU does 32-bit arithmetic and Boolean work in one cycle
// - Results land in a 32-bit accumulator, stored as two halves
// - Bus data passes the input scaler; products pass the product shifter
// - Saturation on: overflow sets flag and clamps to extreme value
// - Saturation off: overflow keeps the wrapped sum
// - Boolean operations never overflow and never saturate
// - Carry moves on arithmetic and one-bit shifts, not loads or logic
// - Add with carry and subtract with borrow use the old carry
// - High-half add only sets carry; high-half subtract only clears it
// - Carry is one after reset and loadable by flag and status ops
// - Carry, overflow and accumulator-zero conditions are output
// - Accumulator low word is given as a computed branch target
// - Stores shift left zero to seven places; accumulator unchanged
// - High store fills from the low half; low store fills zeros
// - One-bit right shift goes through carry, sign kept by sign mode
// - One-bit left shift inserts zero; rotates go through carry
// - Variable shifts and variable bit test use multiplier operand 3:0
// - Normalize shifts left toward normal form; bit tests keep accumulator
// - Eight auxiliary registers chosen by a 3-bit pointer
// - Auxiliary registers load from memory, accumulator, product, immediate
// - Current auxiliary register steps by one or by register zero
// - Sign mode picks sign or zero fill in the 0 to 16 input shift
// - Product shift mode: none, left 1, left 4, right 6
package cad_pkg;
  localparam int ACCUM_W = 32;
  localparam int DATA_W  = 16;
  localparam logic [31:0] SAT_POS = 32'h7FFF_FFFF;
  localparam logic [31:0] SAT_NEG = 32'h8000_0000;
  localparam logic [4:0]  INPUT_SCALING_SHIFTER_MAX = 5'h10;
  localparam logic [1:0]  PSM_NONE   = 2'h0;
  localparam logic [1:0]  PSM_LEFT1  = 2'h1;
  localparam logic [1:0]  PSM_LEFT4  = 2'h2;
  localparam logic [1:0]  PSM_RIGHT6 = 2'h3;
  localparam int PRODUCT_SHIFTER_L1 = 1;
  localparam int PRODUCT_SHIFTER_L4 = 4;
  localparam int PRODUCT_SHIFTER_R6 = 6;
  localparam logic [1:0]  MOD_NONE = 2'h0;
  localparam logic [1:0]  MOD_INC  = 2'h1;
  localparam logic [1:0]  MOD_DEC  = 2'h2;
  localparam logic [1:0]  MOD_IDX0 = 2'h3;
  localparam logic [15:0] AUX_STEP = 16'h0001;
  localparam logic [1:0]  FLAG_CARRY = 2'h0;
  localparam logic [1:0]  FLAG_SEXT  = 2'h1;
  localparam logic [1:0]  FLAG_SATEN = 2'h2;
  localparam int ST_C = 0;
  localparam int ST_OVF = 1;
  localparam int ST_ZERO = 2;
  localparam int ST_SEXT = 3;
  localparam int ST_SATEN = 4;
  localparam int ST_PSM = 5;
  localparam int ST_PTR = 8;
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_ACCUM  = 8'h04;
  localparam logic [7:0] REG_AUX    = 8'h08;
  localparam logic       CARRY_RST = 1'b1;
  localparam logic       SEXT_RST  = 1'b1;
  typedef enum logic [5:0] {
    OP_NOP = 6'h00, OP_LOAD, OP_ADD, OP_SUB, OP_ADD_CARRY, OP_SUB_BORROW,
    OP_AND, OP_OR, OP_XOR, OP_LOAD_VAR, OP_ADD_VAR, OP_SUB_VAR,
    OP_LOAD_PROD, OP_ADD_PROD, OP_SUB_PROD, OP_ADD_AUX, OP_SHL1, OP_SHR1,
    OP_ROT_L, OP_ROT_R, OP_NORMALIZE, OP_BIT_TEST, OP_BIT_VAR, OP_SET_FLAG,
    OP_CLR_FLAG, OP_LOAD_STAT, OP_STORE_HI, OP_STORE_LO, OP_STORE_AUX,
    OP_BRANCH_COMP, OP_AUX_LD, OP_AUX_LD_ACCUM, OP_AUX_LD_PROD, OP_PTR_LD
  } cad_op_t;
endpackage : cad_pkg

/* File: verification/cad_dec_model.sv */
// Decoder and operand bus model facing the datapath op port
`timescale 1ns/1ps
module cad_dec_model (
  input  wire logic       clk_in,
  output cad_pkg::cad_op_t code_out,
  output logic            valid_out,
  output logic [15:0]     data_out,
  output logic [4:0]      shift_out,
  output logic [3:0]      arg_out,
  output logic [1:0]      mod_out,
  output logic            ovf_test_out,
  output logic [31:0]     prod_out,
  output logic [15:0]     mul_opnd_out
);
  initial begin
    code_out = cad_pkg::OP_NOP;
    valid_out = 1'b0;
    data_out = 16'h0000;
    shift_out = 5'h00;
    arg_out = 4'h0;
    mod_out = 2'h0;
    ovf_test_out = 1'b0;
    prod_out = 32'h0000_0000;
    mul_opnd_out = 16'h0000;
  end

  // One op, bus word released to its inverse afterwards
  task automatic issue(input cad_pkg::cad_op_t op, input logic [15:0] d,
                       input logic [4:0] sh, input logic [3:0] a,
                       input logic [1:0] m);
    @(posedge clk_in);
    valid_out <= 1'b1;
    code_out <= op;
    data_out <= d;
    shift_out <= sh;
    arg_out <= a;
    mod_out <= m;
    @(posedge clk_in);
    valid_out <= 1'b0;
    data_out <= ~d;
    #1;
  endtask : issue

  // Two ops on consecutive edges, strobe held high between them
  task automatic issue_pair(input cad_pkg::cad_op_t op_a,
                            input cad_pkg::cad_op_t op_b);
    @(posedge clk_in);
    valid_out <= 1'b1;
    code_out <= op_a;
    data_out <= 16'h0000;
    shift_out <= 5'h00;
    arg_out <= 4'h0;
    mod_out <= 2'h0;
    @(posedge clk_in);
    code_out <= op_b;
    @(posedge clk_in);
    valid_out <= 1'b0;
    data_out <= 16'hFFFF;
    #1;
  endtask : issue_pair

  task automatic ovf_test();
    @(posedge clk_in);
    ovf_test_out <= 1'b1;
    @(posedge clk_in);
    ovf_test_out <= 1'b0;
    #1;
  endtask : ovf_test

  task automatic set_ops(input logic [31:0] p, input logic [15:0] t);
    @(posedge clk_in);
    prod_out <= p;
    mul_opnd_out <= t;
  endtask : set_ops
endmodule : cad_dec_model

/* File: verification/testbench.sv */
// Self-checking bench for the central ALU datapath
`timescale 1ns/1ps
module testbench;
  logic             core_clk = 1'b0;
  logic             sys_rst = 1'b1;
  logic             psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]       paddr;
  logic [31:0]      pwdata, prdata, rd, product, accum;
  cad_pkg::cad_op_t op_code;
  logic             op_valid, ovf_test, store_valid, carry, overflow;
  logic             accum_zero, branch_valid, bit_test;
  logic [15:0]      op_data, mul_opnd, store_data, branch_addr, aux_addr;
  logic [4:0]       op_shift;
  logic [3:0]       op_arg;
  logic [1:0]       aux_mod;
  int               fails = 0;
  int               total_checks = 0;
  int               cycles = 0;
  cad_pkg::cad_op_t sh_op [9] = '{cad_pkg::OP_SHR1, cad_pkg::OP_CLR_FLAG,
    cad_pkg::OP_SHR1, cad_pkg::OP_SHL1, cad_pkg::OP_ROT_L, cad_pkg::OP_ROT_R,
    cad_pkg::OP_SET_FLAG, cad_pkg::OP_CLR_FLAG, cad_pkg::OP_SET_FLAG};
  logic [3:0]  sh_arg [9] = '{4'h0, 4'h1, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0,
                              4'h0, 4'h1};
  logic [31:0] sh_acc [9] = '{32'hFFFF_C000, 32'hFFFF_C000, 32'h7FFF_E000,
    32'hFFFF_C000, 32'hFFFF_8000, 32'hFFFF_C000, 32'hFFFF_C000,
    32'hFFFF_C000, 32'hFFFF_C000};
  logic        sh_c [9] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1,
                            1'b0, 1'b0};
  logic [31:0] pr_exp [4] = '{32'h0000_0400, 32'h0000_0800, 32'h0000_4000,
                              32'h0000_0010};
  logic [1:0]  ax_mod [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
  logic [31:0] ax_exp [4] = '{32'h0100, 32'h0101, 32'h0202, 32'h0201};

  cad_datapath dut (
    .core_clk_in(core_clk), .sys_rst_in(sys_rst), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .op_valid_in(op_valid), .op_code_in(op_code),
    .op_data_in(op_data), .op_shift_in(op_shift), .op_arg_in(op_arg),
    .aux_mod_in(aux_mod), .product_in(product), .mul_opnd_in(mul_opnd),
    .ovf_test_in(ovf_test), .accum_out(accum), .store_data_out(store_data),
    .store_valid_out(store_valid), .carry_out(carry),
    .overflow_out(overflow), .accum_zero_out(accum_zero),
    .branch_addr_out(branch_addr), .branch_valid_out(branch_valid),
    .bit_test_out(bit_test), .aux_addr_out(aux_addr));

  cad_dec_model dec (
    .clk_in(core_clk), .code_out(op_code), .valid_out(op_valid),
    .data_out(op_data), .shift_out(op_shift), .arg_out(op_arg),
    .mod_out(aux_mod), .ovf_test_out(ovf_test), .prod_out(product),
    .mul_opnd_out(mul_opnd));

  always #10 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      final_report();
    end
  end

  task automatic check(input logic [31:0] got, exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : apb

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    apb(1'b0, cad_pkg::REG_STATUS, 32'h0);
    check(rd, 32'h0000_000D, "reset status");
    $display("test reset done");
    dec.issue(cad_pkg::OP_LOAD, 16'hFFFF, 5'h00, 4'h0, 2'h0);
    dec.issue(cad_pkg::OP_ADD, 16'h0001, 5'h00, 4'h0, 2'h0);
    check(accum, 32'h0, "add sum");
    check(carry, 32'h1, "add carry");
    check(accum_zero, 32'h1, "zero flag");
    dec.issue(cad_pkg::OP_ADD_CARRY, 16'h0000, 5'h00, 4'h0, 2'h0);
    check(accum, 32'h1, "add carry in");
    dec.issue(cad_pkg::OP_SUB_BORROW, 16'h0000, 5'h00, 4'h0, 2'h0);
    check(accum, 32'h0, "sub borrow in");
    $display("test carry done");
    apb(1'b1, cad_pkg::REG_STATUS, 32'h18);
    dec.issue(cad_pkg::OP_LOAD, 16'h7FFF, 5'h10, 4'h0, 2'h0);
    dec.issue(cad_pkg::OP_ADD, 16'h7FFF, 5'h10, 4'h0, 2'h0);
    check(accum, cad_pkg::SAT_POS, "sat pos");
    check(overflow, 32'h1, "ovf set");
    check(carry, 32'h1, "high add carry");
    dec.issue(cad_pkg::OP_LOAD, 16'h8000, 5'h10, 4'h0, 2'h0);
    dec.issue(cad_pkg::OP_ADD, 16'h8000, 5'h10, 4'h0, 2'h0);
    check(accum, cad_pkg::SAT_NEG, "sat neg");
    dec.ovf_test();
    check(overflow, 32'h0, "ovf cleared");
    apb(1'b1, cad_pkg::REG_STATUS, 32'h08);
    dec.issue(cad_pkg::OP_LOAD, 16'h7FFF, 5'h10, 4'h0, 2'h0);
    dec.issue(cad_pkg::OP_ADD, 16'h7FFF, 5'h10, 4'h0, 2'h0);
    check(accum, 32'hFFFE_0000, "wrapped");
    check(overflow, 32'h1, "ovf wrap");
    apb(1'b1, cad_pkg::REG_STATUS, 32'h0A);
    check(overflow, 32'h0, "ovf write clear");
    dec.issue(cad_pkg::OP_XOR, 16'hFFFF, 5'h00, 4'h0, 2'h0);
    check(accum, 32'h0001_FFFF, "xor");
    check(overflow, 32'h0, "xor ovf");
    check(carry, 32'h1, "xor carry");
    $display("test saturation done");
    dec.issue(cad_pkg::OP_LOAD, 16'h8001, 5'h00, 4'h0, 2'h0);
    for (int i = 0; i < 9; i++) begin
      dec.issue(sh_op[i], 16'h0000, 5'h00, sh_arg[i], 2'h0);
      check(accum, sh_acc[i], "shift acc");
      check(carry, sh_c[i], "shift carry");
    end
    $display("test shifts done");
    dec.issue(cad_pkg::OP_LOAD, 16'h1234, 5'h08, 4'h0, 2'h0);
    dec.issue(cad_pkg::OP_STORE_HI, 16'h0000, 5'h04, 4'h0, 2'h0);
    check(store_data, 32'h0123, "store hi");
    check(store_valid, 32'h1, "store strobe");
    dec.issue(cad_pkg::OP_STORE_LO, 16'h0000, 5'h03, 4'h0, 2'h0);
    check(store_data, 32'hA000, "store lo");
    check(accum, 32'h0012_3400, "acc kept");
    dec.issue(cad_pkg::OP_BRANCH_COMP, 16'h0000, 5'h00, 4'h0, 2'h0);
    check(branch_addr, 32'h3400, "branch addr");
    check(branch_valid, 32'h1, "branch strobe");
    $display("test store done");
    dec.set_ops(32'h0000_0400, 16'h0005);
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, cad_pkg::REG_STATUS, 32'h08 | (m << 5));
      dec.issue(cad_pkg::OP_LOAD_PROD, 16'h0000, 5'h00, 4'h0, 2'h0);
      check(accum, pr_exp[m], "product mode");
    end
    dec.issue(cad_pkg::OP_LOAD_VAR, 16'h0001, 5'h00, 4'h0, 2'h0);
    check(accum, 32'h20, "var load");
    dec.issue(cad_pkg::OP_BIT_VAR, 16'h0020, 5'h00, 4'h0, 2'h0);
    check(bit_test, 32'h1, "var bit");
    check(accum, 32'h20, "bit keeps acc");
    dec.issue(cad_pkg::OP_BIT_TEST, 16'h0020, 5'h00, 4'h4, 2'h0);
    check(bit_test, 32'h0, "fixed bit");
    $display("test operands done");
    for (int k = 0; k < 4; k++) begin
      dec.issue(k == 0 ? cad_pkg::OP_AUX_LD : cad_pkg::OP_NOP, 16'h0100,
                5'h00, 4'h0, ax_mod[k]);
      apb(1'b0, cad_pkg::REG_AUX, 32'h0);
      check(rd, ax_exp[k], "aux reg");
      check(aux_addr, ax_exp[k], "aux addr");
    end
    dec.issue(cad_pkg::OP_PTR_LD, 16'h0003, 5'h00, 4'h0, 2'h0);
    dec.issue(cad_pkg::OP_AUX_LD_ACCUM, 16'h0000, 5'h00, 4'h0, 2'h0);
    check(aux_addr, 32'h0020, "pointer select");
    dec.issue(cad_pkg::OP_ADD_AUX, 16'h0000, 5'h00, 4'h0, 2'h3);
    check(accum, 32'h40, "aux to alu");
    check(aux_addr, 32'h0221, "aux index step");
    dec.issue(cad_pkg::OP_STORE_AUX, 16'h0000, 5'h00, 4'h0, 2'h0);
    check(store_data, 32'h0221, "aux store");
    dec.issue(cad_pkg::OP_SUB_PROD, 16'h0000, 5'h00, 4'h0, 2'h0);
    check(accum, 32'h30, "sub product");
    dec.issue(cad_pkg::OP_NORMALIZE, 16'h0000, 5'h00, 4'h0, 2'h0);
    check(accum, 32'h60, "normalize");
    dec.issue_pair(cad_pkg::OP_ROT_L, cad_pkg::OP_ROT_R);
    check(accum, 32'h60, "rotate pair");
    check(carry, 32'h1, "rotate pair carry");
    dec.issue(cad_pkg::OP_SUB, 16'h0001, 5'h10, 4'h0, 2'h0);
    check(carry, 32'h0, "high sub borrow");
    dec.issue(cad_pkg::OP_LOAD_STAT, 16'h0249, 5'h00, 4'h0, 2'h0);
    apb(1'b0, cad_pkg::REG_STATUS, 32'h0);
    check(rd, 32'h0000_0249, "status load");
    dec.issue(cad_pkg::OP_AUX_LD_PROD, 16'h0000, 5'h00, 4'h0, 2'h0);
    check(aux_addr, 32'h0400, "aux from product");
    dec.issue(cad_pkg::OP_AND, 16'h00FF, 5'h00, 4'h0, 2'h0);
    check(accum, 32'h60, "and mask");
    apb(1'b0, 8'h0C, 32'h0);
    check(err, 32'h1, "unmapped error");
    $display("test aux done");
    final_report();
  end
endmodule : testbench
